// ### hdl/serial_b_cfg.sv
// Configuration register of serial port B with APB access, strap load and clock select.
// Assumes a single 50 MHz clock; mode and strap pins may be asynchronous, port A state is not.
// Contract
// - Bit 7 selects 2 MHz over 1.8462 MHz
// - Bit 4 routes interrupt to IRQ3 or IRQ4
// - Bits 3:1 select one of eight windows
// - Port operates only while enable bit set
// - Hardware modes load straps; software modes disable
// - Software modes reset address select to 000
// - Software modes reset interrupt select to IRQ3
// - Hard reset presents 0RR0 0000
// - Address clash with port A disables port B
// - Shared interrupt line between ports is allowed
// - Enable write leaves direct powerdown bit alone
//
// Chosen here: register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "serial_b_cfg_map.svh"
module serial_b_cfg
	import serial_b_cfg_pkg::*;
#(
	parameter int unsigned ACC_W = 24
) (
	// Clock and reset
	input  wire logic         core_clk,
	input  wire logic         reset,
	// APB slave
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [11:0]  paddr,
	input  wire logic [31:0]  pwdata,
	output var  logic [31:0]  prdata,
	output var  logic         pready,
	output var  logic         pslverr,
	// Powerup configuration
	input  wire config_mode_t config_mode,
	input  wire strap_t       strap,
	// Port A state
	input  wire port_a_view_t port_a,
	// Port B core control
	input  wire logic         direct_powerdown_bit,
	output var  port_ctl_t    port_ctl,
	output var  logic         powerdown_view,
	output var  logic         uart_clk_en
);
	// ======================================================================
	// Elaboration checks
	if (ACC_W < 22 || ACC_W > 30) begin : g_bad_acc
		$error("ACC_W must lie between 22 and 30.");
	end

	localparam logic [ACC_W-1:0] STD_STEP   =
		ACC_W'((64'(`UART_STD_HZ) << ACC_W) / 64'(`CORE_CLK_HZ));
	localparam logic [ACC_W-1:0] MUSIC_STEP =
		ACC_W'((64'(`UART_MUSIC_HZ) << ACC_W) / 64'(`CORE_CLK_HZ));

	// ======================================================================
	// State
	// Mode and strap pins as one sample, for the pin synchroniser.
	typedef struct packed {
		config_mode_t mode;
		strap_t       strap;
	} pin_sample_t;

	typedef struct packed {
		strap_state_t     phase;
		pin_sample_t      sync1;
		pin_sample_t      sync2;
		pin_sample_t      sync3;
		pin_sample_t      pins;
		logic [1:0]       fill;
		cfg_fields_t      cfg;
		logic [ACC_W-1:0] acc;
		logic             clk_en;
		port_ctl_t        ctl;
		logic             pd_view;
		logic [31:0]      rdata;
		logic             ready;
		logic             err;
	} state_t;

	state_t state;
	state_t next_state;

	function automatic logic [9:0] window_base(input logic [2:0] sel);
		case (sel)
			3'b000:  window_base = `WIN_0;
			3'b001:  window_base = `WIN_1;
			3'b010:  window_base = `WIN_2;
			3'b011:  window_base = `WIN_3;
			3'b100:  window_base = `WIN_4;
			3'b101:  window_base = `WIN_5;
			3'b110:  window_base = `WIN_6;
			default: window_base = `WIN_7;
		endcase
	endfunction

	function automatic logic [7:0] pack_cfg(input cfg_fields_t c);
		logic [7:0] v;
		v = 8'h00;
		v[`MUSIC_CLK_BIT]               = c.music_clock_select;
		v[`IRQ_SEL_BIT]                 = c.interrupt_line_select;
		v[`ADDR_SEL_HI:`ADDR_SEL_LO]    = c.port_address_select;
		v[`ENABLE_BIT]                  = c.port_enable_bit;
		pack_cfg = v;
	endfunction

	function automatic logic is_hw_mode(input config_mode_t m);
		is_hw_mode = (m == hw_basic_config_mode) || (m == hw_extended_config_mode);
	endfunction

	logic setup;
	logic access;
	logic [ACC_W:0] acc_sum;
	logic clash;
	logic pin_load;
	assign setup  = psel && !penable;
	assign access = psel && penable && state.ready;
	assign pin_load = (state.phase == strap_wait) && (state.fill == `PIN_SYNC_FILL)
		&& (state.sync2 == state.sync3);

	always_comb begin
		next_state       = state;
		next_state.ready = 1'b0;
		next_state.err   = 1'b0;
		acc_sum          = '0;
		clash            = 1'b0;
		// ==================================================================
		// Pin synchroniser: a new value counts once stages two and three agree.
		next_state.sync1 = '{mode: config_mode, strap: strap};
		next_state.sync2 = state.sync1;
		next_state.sync3 = state.sync2;
		if (state.sync2 == state.sync3) begin
			next_state.pins = state.sync3;
		end
		// ==================================================================
		// Powerup load once the synchroniser has filled, so a pin still settling is never taken.
		case (state.phase)
			strap_wait: begin
				if (state.fill != `PIN_SYNC_FILL) begin
					next_state.fill = state.fill + 2'h1;
				end else if (pin_load) begin
					if (is_hw_mode(state.sync3.mode)) begin
						next_state.cfg.port_enable_bit       = state.sync3.strap.enable;
						next_state.cfg.interrupt_line_select = state.sync3.strap.irq_sel;
						next_state.cfg.port_address_select   = state.sync3.strap.addr_sel;
					end else begin
						next_state.cfg.port_enable_bit       = 1'b0;
						next_state.cfg.interrupt_line_select = 1'b0;
						next_state.cfg.port_address_select   = 3'b000;
					end
					next_state.phase = strap_done;
				end
			end
			strap_done: begin
				next_state.phase = strap_done;
			end
			default: begin
				next_state.phase = strap_done;
			end
		endcase
		// ==================================================================
		// APB slave: one wait state, so pready rises in the second access cycle.
		if (setup || (psel && penable && !state.ready)) begin
			next_state.ready = psel && penable;
		end
		if (psel && penable && !state.ready) begin
			next_state.rdata = 32'h0000_0000;
			case (paddr)
				`SERIAL_B_CONFIG_ADDR: begin
					next_state.rdata = {24'h00_0000, pack_cfg(state.cfg)};
				end
				`PORT_A_VIEW_ADDR: begin
					next_state.rdata = {27'h000_0000, state.ctl.addr_clash, state.pd_view,
						state.ctl.port_active, 2'b00};
				end
				`STRAP_VIEW_ADDR: begin
					next_state.rdata = {25'h000_0000, state.pins};
				end
				default: begin
					next_state.err = 1'b1;
				end
			endcase
		end
		if (access && pwrite && (paddr == `SERIAL_B_CONFIG_ADDR)) begin
			// Bits 6:5 are masked out and stay zero.
			next_state.cfg.music_clock_select    = pwdata[`MUSIC_CLK_BIT];
			next_state.cfg.interrupt_line_select = pwdata[`IRQ_SEL_BIT];
			next_state.cfg.port_address_select   = pwdata[`ADDR_SEL_HI:`ADDR_SEL_LO];
			next_state.cfg.port_enable_bit       = pwdata[`ENABLE_BIT];
		end
		if (access && !pwrite) begin
			next_state.rdata = 32'h0000_0000;
		end
		// ==================================================================
		// Port steering. The clash only gates the port; powerdown is untouched.
		clash = state.cfg.port_enable_bit && port_a.enable
			&& (port_a.addr_sel == state.cfg.port_address_select);
		next_state.ctl.addr_clash  = clash;
		next_state.ctl.port_active = state.cfg.port_enable_bit && !clash;
		next_state.ctl.io_base     = window_base(state.cfg.port_address_select);
		// Port A may use the same line; no lockout is applied here.
		next_state.ctl.irq3_route  = !state.cfg.interrupt_line_select;
		next_state.ctl.irq4_route  = state.cfg.interrupt_line_select;
		// Powerdown is read through a mux and never cleared by enabling.
		next_state.pd_view = direct_powerdown_bit;
		// ==================================================================
		// Core clock enable from a phase accumulator; jitter is one core cycle.
		acc_sum = {1'b0, state.acc}
			+ {1'b0, (state.cfg.music_clock_select ? MUSIC_STEP : STD_STEP)};
		next_state.acc    = acc_sum[ACC_W-1:0];
		next_state.clk_en = acc_sum[ACC_W];
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state       <= '0;
			state.phase <= strap_wait;
		end else begin
			state <= next_state;
		end
	end

	assign prdata         = state.rdata;
	assign pready         = state.ready;
	assign pslverr        = state.err;
	assign port_ctl       = state.ctl;
	assign powerdown_view = state.pd_view;
	assign uart_clk_en    = state.clk_en;

	// ======================================================================
	// Assertions
	sequence cfg_write_s;
		psel && penable && pready && pwrite && (paddr == `SERIAL_B_CONFIG_ADDR);
	endsequence

	music_rate_a: assert property (@(posedge core_clk) disable iff (reset)
		cfg_write_s ##1 1 |-> state.cfg.music_clock_select == $past(pwdata[`MUSIC_CLK_BIT]))
		else $error("Music clock select did not follow the write.");
	irq_route_a: assert property (@(posedge core_clk) disable iff (reset)
		state.phase == strap_done ##1 1 |-> port_ctl.irq4_route
			== $past(state.cfg.interrupt_line_select) && port_ctl.irq3_route != port_ctl.irq4_route)
		else $error("Interrupt route does not match select bit.");
	window_map_a: assert property (@(posedge core_clk) disable iff (reset)
		$past(state.cfg.port_address_select) == 3'b001 |-> port_ctl.io_base == `WIN_1)
		else $error("Window base wrong for code one.");
	enable_gate_a: assert property (@(posedge core_clk) disable iff (reset)
		!state.cfg.port_enable_bit |=> !port_ctl.port_active)
		else $error("Port active while disabled.");
	strap_load_a: assert property (@(posedge core_clk) disable iff (reset)
		pin_load && is_hw_mode(state.sync3.mode)
			|=> state.cfg.port_enable_bit == $past(strap.enable))
		else $error("Enable strap not loaded.");
	sw_defaults_a: assert property (@(posedge core_clk) disable iff (reset)
		pin_load && !is_hw_mode(state.sync3.mode)
			|=> state.cfg.port_address_select == 3'b000 && !state.cfg.port_enable_bit)
		else $error("Software mode defaults wrong.");
	sw_irq_a: assert property (@(posedge core_clk) disable iff (reset)
		pin_load && !is_hw_mode(state.sync3.mode)
			|=> !state.cfg.interrupt_line_select)
		else $error("Software mode interrupt default wrong.");
	clash_off_a: assert property (@(posedge core_clk) disable iff (reset)
		clash |=> !port_ctl.port_active && port_ctl.addr_clash)
		else $error("Clash did not disable port B.");
	reserved_zero_a: assert property (@(posedge core_clk) disable iff (reset)
		pready && !pwrite && paddr == `SERIAL_B_CONFIG_ADDR |-> prdata[6:5] == 2'b00)
		else $error("Reserved bits read nonzero.");
	powerdown_keep_a: assert property (@(posedge core_clk) disable iff (reset)
		cfg_write_s ##1 1 |-> powerdown_view == $past(direct_powerdown_bit))
		else $error("Powerdown view disturbed by enable write.");

	// ======================================================================
	// Assertions on reset values, strap loads, port steering, the bus handshake and the clock enable
	reset_value_a: assert property (@(posedge core_clk) disable iff (reset)
		$past(reset) |-> pack_cfg(state.cfg) == `SERIAL_B_CONFIG_RESET && !port_ctl.port_active)
		else $error("Register not at reset value after hard reset.");
	write_mask_a: assert property (@(posedge core_clk) disable iff (reset)
		cfg_write_s ##1 1 |-> pack_cfg(state.cfg) == ($past(pwdata[7:0]) & `WRITABLE_MASK))
		else $error("Stored value differs from masked write data.");
	strap_fields_a: assert property (@(posedge core_clk) disable iff (reset)
		pin_load && is_hw_mode(state.sync3.mode) |=> state.cfg.interrupt_line_select
			== $past(strap.irq_sel) && state.cfg.port_address_select == $past(strap.addr_sel))
		else $error("Interrupt or address strap not loaded.");
	strap_hold_a: assert property (@(posedge core_clk) disable iff (reset)
		state.phase == strap_done |=> state.phase == strap_done)
		else $error("Strap load repeated after powerup.");
	active_on_a: assert property (@(posedge core_clk) disable iff (reset)
		state.cfg.port_enable_bit && !clash |=> port_ctl.port_active)
		else $error("Enabled port without clash stayed inactive.");
	clash_free_a: assert property (@(posedge core_clk) disable iff (reset)
		!clash |=> !port_ctl.addr_clash)
		else $error("Clash flag raised without a clash.");
	window_zero_a: assert property (@(posedge core_clk) disable iff (reset)
		$past(state.phase == strap_done && state.cfg.port_address_select == 3'b000)
			|-> port_ctl.io_base == `WIN_0)
		else $error("Window base wrong for code zero.");
	ready_pulse_a: assert property (@(posedge core_clk) disable iff (reset)
		pready |=> !pready)
		else $error("Ready stood longer than one cycle.");
	error_ready_a: assert property (@(posedge core_clk) disable iff (reset)
		pslverr |-> pready)
		else $error("Error flagged outside a completing transfer.");
	clk_pulse_a: assert property (@(posedge core_clk) disable iff (reset)
		uart_clk_en |=> !uart_clk_en)
		else $error("Serial clock enable stood two cycles.");
endmodule
`default_nettype wire

// ### hdl/serial_b_cfg_map.svh
// Register map, field positions, reset values and clock rates of the port B configuration block.
// Assumes inclusion by a package or module that needs these names.
`ifndef SERIAL_B_CFG_MAP_SVH
`define SERIAL_B_CFG_MAP_SVH
// ==========================================================================
// Register offsets
`define SERIAL_B_CONFIG_IDX      8'h40
`define SERIAL_B_CONFIG_ADDR     12'h040
`define PORT_A_VIEW_ADDR         12'h044
`define STRAP_VIEW_ADDR          12'h048
// ==========================================================================
// Field positions
`define MUSIC_CLK_BIT            7
`define IRQ_SEL_BIT              4
`define ADDR_SEL_HI              3
`define ADDR_SEL_LO              1
`define ENABLE_BIT               0
`define WRITABLE_MASK            8'h9F
// ==========================================================================
// Reset values
`define SERIAL_B_CONFIG_RESET    8'h00
// ==========================================================================
// Clock rates
`define CORE_CLK_HZ              50000000
`define UART_STD_HZ              1846200
`define UART_MUSIC_HZ            2000000
// ==========================================================================
// Timing counts
`define PIN_SYNC_FILL            2'h3
// ==========================================================================
// Decoded window bases, one for each address select code
`define WIN_0                    10'h3F8
`define WIN_1                    10'h2F8
`define WIN_2                    10'h220
`define WIN_3                    10'h228
`define WIN_4                    10'h238
`define WIN_5                    10'h2E8
`define WIN_6                    10'h338
`define WIN_7                    10'h3E8
`endif

// ### hdl/serial_b_cfg_pkg.sv
// Types shared by the port B configuration block.
// Assumes the map header sits beside it.
`include "serial_b_cfg_map.svh"
package serial_b_cfg_pkg;
	// ======================================================================
	// Configuration modes
	typedef enum logic [1:0] {
		hw_basic_config_mode       = 2'b00,
		hw_extended_config_mode    = 2'b01,
		sw_motherboard_config_mode = 2'b10,
		sw_addin_config_mode       = 2'b11
	} config_mode_t;

	typedef enum logic [0:0] {
		strap_wait = 1'b0,
		strap_done = 1'b1
	} strap_state_t;

	// Stored register fields.
	typedef struct packed {
		logic       music_clock_select;
		logic       interrupt_line_select;
		logic [2:0] port_address_select;
		logic       port_enable_bit;
	} cfg_fields_t;

	// Strap pins caught at powerup.
	typedef struct packed {
		logic       enable;
		logic       irq_sel;
		logic [2:0] addr_sel;
	} strap_t;

	// Port A view needed for clash detection.
	typedef struct packed {
		logic       enable;
		logic [2:0] addr_sel;
	} port_a_view_t;

	// Outputs steering the serial core.
	typedef struct packed {
		logic       port_active;
		logic       irq3_route;
		logic       irq4_route;
		logic       addr_clash;
		logic [9:0] io_base;
	} port_ctl_t;
endpackage

// ### verification/serial_b_config_test.sv
// Self-checking bench for the port B configuration block.
// Assumes the map header and package are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "serial_b_cfg_map.svh"
module serial_port_b_config_test;
	import serial_b_cfg_pkg::*;
	logic         core_clk = 0;
	logic         reset = 1;
	logic         psel = 0;
	logic         penable = 0;
	logic         pwrite = 0;
	logic [11:0]  paddr = '0;
	logic [31:0]  pwdata = '0;
	logic [31:0]  prdata;
	logic         pready;
	logic         pslverr;
	config_mode_t config_mode = sw_motherboard_config_mode;
	strap_t       strap = '0;
	port_a_view_t port_a = '0;
	logic         dpd = 0;
	port_ctl_t    port_ctl;
	logic         powerdown_view;
	logic         uart_clk_en;
	int           pulses;
	int           miscompares = 0;
	int           total_checks = 0;
	logic [31:0]  q;
	logic         e;
	int           p0;
	logic [9:0]   win_tab [8] = '{`WIN_0, `WIN_1, `WIN_2, `WIN_3, `WIN_4, `WIN_5, `WIN_6, `WIN_7};

	always #10 core_clk = ~core_clk;

	serial_b_cfg DUT (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .config_mode(config_mode), .strap(strap), .port_a(port_a),
		.direct_powerdown_bit(dpd), .port_ctl(port_ctl), .powerdown_view(powerdown_view),
		.uart_clk_en(uart_clk_en));
	serial_core_model core (.core_clk(core_clk), .reset(reset), .uart_clk_en(uart_clk_en),
		.pulses(pulses));

	// ======================================================================
	// Helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Request held until pready is sampled high; read data taken at that edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk(32'(pready), 1, "pready");
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic do_reset(input config_mode_t m, input strap_t s);
		@(posedge core_clk);
		reset <= 1;
		config_mode <= m;
		strap <= s;
		repeat (6) @(posedge core_clk);
		reset <= 0;
		repeat (6) @(posedge core_clk);
	endtask

	task automatic settle();
		repeat (3) @(posedge core_clk);
	endtask

	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ======================================================================
	// Tests
	initial begin
		for (int m = 0; m < 4; m++) begin
			do_reset(config_mode_t'(m), 5'h1D);
			apb(0, `SERIAL_B_CONFIG_ADDR, 0);
			chk(q, (m < 2) ? 32'h0000_001B : 32'h0000_0000, "config after reset");
			chk(32'(e), 0, "error on mapped read");
			chk(32'(port_ctl.io_base), (m < 2) ? `WIN_5 : `WIN_0, "base after reset");
			apb(0, `STRAP_VIEW_ADDR, 0);
			chk(q, 32'((m << 5) | 5'h1D), "strap view");
		end
		$display("reset tests done");
		for (int c = 0; c < 8; c++) begin
			apb(1, `SERIAL_B_CONFIG_ADDR, 32'hFFFF_FF61 & ~32'h80 | (c << 1) | ((c & 1) << 4));
			apb(0, `SERIAL_B_CONFIG_ADDR, 0);
			chk(q, 32'(((c & 1) << 4) | (c << 1) | 1), "readback masks reserved");
			settle();
			chk(32'(port_ctl.io_base), 32'(win_tab[c]), "window base");
			chk(32'({port_ctl.irq4_route, port_ctl.irq3_route}), (c & 1) ? 2 : 1, "irq");
			chk(32'(port_ctl.port_active), 1, "active");
		end
		apb(1, `SERIAL_B_CONFIG_ADDR, 0);
		settle();
		chk(32'(port_ctl.port_active), 0, "disabled");
		$display("window tests done");
		port_a <= '{enable: 1'b1, addr_sel: 3'd2};
		apb(1, `SERIAL_B_CONFIG_ADDR, 32'h0000_0005);
		settle();
		chk(32'({port_ctl.port_active, port_ctl.addr_clash, powerdown_view}), 2, "clash");
		apb(0, `PORT_A_VIEW_ADDR, 0);
		chk(q, 32'h0000_0010, "clash status");
		port_a <= '{enable: 1'b0, addr_sel: 3'd2};
		settle();
		chk(32'(port_ctl.port_active), 1, "clash gone");
		dpd <= 1;
		apb(1, `SERIAL_B_CONFIG_ADDR, 32'h0000_0001);
		settle();
		chk(32'(powerdown_view), 1, "powerdown kept");
		apb(0, `PORT_A_VIEW_ADDR, 0);
		chk(q, 32'h0000_000C, "status view");
		dpd <= 0;
		$display("clash and powerdown tests done");
		for (int k = 0; k < 2; k++) begin
			apb(1, `SERIAL_B_CONFIG_ADDR, k ? 32'h0000_0081 : 32'h0000_0001);
			settle();
			p0 = pulses;
			repeat (10000) @(posedge core_clk);
			p0 = pulses - p0 - (k ? `UART_MUSIC_HZ / 5000 : `UART_STD_HZ / 5000);
			chk(32'(p0 >= -1 && p0 <= 1), 1, "clock rate");
		end
		apb(0, 12'h10C, 0);
		chk({q[30:0], e}, 1, "unmapped read");
		$display("clock and decode tests done");
		print_verdict();
	end

	initial begin
		#(20 * 40000);
		miscompares++;
		print_verdict();
	end
endmodule
`default_nettype wire

// ### verification/serial_core_model.sv
// Model of the serial core that takes the port B clock enable.
// Assumes it shares the core clock with the configuration block.
`timescale 1ns/1ns
`default_nettype none
module serial_core_model (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic reset,
	// Clock enable from the configuration block
	input  wire logic uart_clk_en,
	// Pulses seen since reset
	output var  int   pulses
);
	// ======================================================================
	// Pulse counter
	// A running total lets the bench judge the mean rate over any window.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset)
			pulses <= 0;
		else if (uart_clk_en === 1'b1)
			pulses <= pulses + 1;
	end
endmodule
`default_nettype wire
